// >>> design/cal_volume_pkg.sv
// Register map, reset values and carrier types for the channel 3/4 trim registers.
package cal_volume_pkg;

   // ==========================================================================
   // Register offsets
   localparam logic [7:0] THIRD_GAIN_REGISTER_ADDR   = 8'h49;
   localparam logic [7:0] THIRD_PHASE_REGISTER_ADDR  = 8'h4a;
   localparam logic [7:0] FOURTH_VOLUME_REGISTER_ADDR = 8'h4d;
   localparam logic [7:0] FOURTH_GAIN_REGISTER_ADDR  = 8'h4e;
   localparam logic [7:0] FOURTH_PHASE_REGISTER_ADDR = 8'h4f;

   // ==========================================================================
   // Reset values
   localparam logic [7:0] GAIN_REGISTER_RESET   = 8'h80;
   localparam logic [7:0] PHASE_REGISTER_RESET  = 8'h00;
   localparam logic [7:0] VOLUME_REGISTER_RESET = 8'hc9;

   // ==========================================================================
   // Field positions and decode constants
   localparam int         GAIN_FIELD_LSB    = 4;
   localparam int         GAIN_FIELD_MSB    = 7;
   localparam logic [3:0] GAIN_RESERVED_VAL = 4'h0;
   localparam logic [4:0] GAIN_ZERO_CODE    = 5'h08;
   localparam logic [8:0] VOLUME_ZERO_CODE  = 9'h0c9;
   localparam logic [7:0] VOLUME_MUTE_CODE  = 8'h00;
   localparam logic [7:0] UNMAPPED_READ_VAL = 8'h00;

   // ==========================================================================
   // Carrier types
   typedef struct packed {
      logic       wr;     // Write strobe.
      logic       rd;     // Read strobe.
      logic [7:0] addr;   // Register offset.
      logic [7:0] wdata;  // Write data.
   } reg_req_type;

   typedef struct packed {
      logic       valid;  // Read data valid, one cycle.
      logic [7:0] data;   // Read data.
   } reg_rsp_type;

   typedef struct packed {
      logic signed [4:0] gain_tenth_db;   // Gain trim in 0.1 dB steps.
      logic        [7:0] phase_delay;     // Delay in modulator clock cycles.
   } channel_trim_type;

endpackage : cal_volume_pkg

// >>> design/channel_cal_volume_regs.sv
// Calibration registers for input channels 3 and 4, volume register for channel 4, with phase delay lines.
`timescale 1ns/100ps

module channel_cal_volume_regs
   import cal_volume_pkg::*;
#(
   parameter int DELAY_DEPTH = 255
) (
   input  wire logic              clk,                    // 250 MHz clock.
   input  wire logic              rst_n,                  // Asynchronous reset, active low.
   input  wire reg_req_type       reg_req,                // Register access request.
   output reg_rsp_type            reg_rsp,                // Register read answer.
   input  wire logic              mod_tick,               // One pulse per modulator clock cycle.
   input  wire logic [1:0]        pdm_in,                 // Channel bits: [0] ch3, [1] ch4.
   output logic [1:0]             pdm_delayed,            // Phase-delayed channel bits.
   output channel_trim_type       third_trim,             // Channel 3 decoded trims.
   output channel_trim_type       fourth_trim,            // Channel 4 decoded trims.
   output logic                   fourth_volume_mute,     // Channel 4 muted.
   output logic signed [8:0]      fourth_volume_half_db   // Channel 4 volume in 0.5 dB steps.
);

   // ==========================================================================
   // Reset synchroniser
   // Reset takes hold at once but is released on a clock edge, so every register
   // leaves reset on the same edge. Only the second stage is read onward, which
   // keeps a metastable first stage away from the register bank.
   logic sync1_reg;
   logic sync2_reg;
   logic rst_sync_n;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= 1'b1;
         sync2_reg <= sync1_reg;
      end
   end
   assign rst_sync_n = sync2_reg;

   // ==========================================================================
   // Register storage
   // Reads use the stored value, so a read and a write to one offset on the same
   // edge answer the old contents. Offsets outside the map are never stored.
   logic [3:0]  third_gain_trim_reg,     third_gain_trim_next;
   logic [7:0]  third_phase_delay_reg,   third_phase_delay_next;
   logic [7:0]  fourth_volume_level_reg, fourth_volume_level_next;
   logic [3:0]  fourth_gain_trim_reg,    fourth_gain_trim_next;
   logic [7:0]  fourth_phase_delay_reg,  fourth_phase_delay_next;
   reg_rsp_type rsp_reg,                 rsp_next;

   always_comb begin
      third_gain_trim_next     = third_gain_trim_reg;
      third_phase_delay_next   = third_phase_delay_reg;
      fourth_volume_level_next = fourth_volume_level_reg;
      fourth_gain_trim_next    = fourth_gain_trim_reg;
      fourth_phase_delay_next  = fourth_phase_delay_reg;
      rsp_next.valid           = reg_req.rd;
      rsp_next.data            = rsp_reg.data;
      if (reg_req.wr) begin
         case (reg_req.addr)
            THIRD_GAIN_REGISTER_ADDR: begin
               third_gain_trim_next = reg_req.wdata[GAIN_FIELD_MSB:GAIN_FIELD_LSB];
            end
            THIRD_PHASE_REGISTER_ADDR: begin
               third_phase_delay_next = reg_req.wdata;
            end
            FOURTH_VOLUME_REGISTER_ADDR: begin
               fourth_volume_level_next = reg_req.wdata;
            end
            FOURTH_GAIN_REGISTER_ADDR: begin
               fourth_gain_trim_next = reg_req.wdata[GAIN_FIELD_MSB:GAIN_FIELD_LSB];
            end
            FOURTH_PHASE_REGISTER_ADDR: begin
               fourth_phase_delay_next = reg_req.wdata;
            end
            default: begin
            end
         endcase
      end
      if (reg_req.rd) begin
         case (reg_req.addr)
            THIRD_GAIN_REGISTER_ADDR: begin
               rsp_next.data = {third_gain_trim_reg, GAIN_RESERVED_VAL};
            end
            THIRD_PHASE_REGISTER_ADDR: begin
               rsp_next.data = third_phase_delay_reg;
            end
            FOURTH_VOLUME_REGISTER_ADDR: begin
               rsp_next.data = fourth_volume_level_reg;
            end
            FOURTH_GAIN_REGISTER_ADDR: begin
               rsp_next.data = {fourth_gain_trim_reg, GAIN_RESERVED_VAL};
            end
            FOURTH_PHASE_REGISTER_ADDR: begin
               rsp_next.data = fourth_phase_delay_reg;
            end
            default: begin
               rsp_next.data = UNMAPPED_READ_VAL;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         third_gain_trim_reg     <= GAIN_REGISTER_RESET[GAIN_FIELD_MSB:GAIN_FIELD_LSB];
         fourth_gain_trim_reg    <= GAIN_REGISTER_RESET[GAIN_FIELD_MSB:GAIN_FIELD_LSB];
         third_phase_delay_reg   <= PHASE_REGISTER_RESET;
         fourth_phase_delay_reg  <= PHASE_REGISTER_RESET;
         fourth_volume_level_reg <= VOLUME_REGISTER_RESET;
         rsp_reg                 <= '0;
      end else begin
         third_gain_trim_reg     <= third_gain_trim_next;
         third_phase_delay_reg   <= third_phase_delay_next;
         fourth_volume_level_reg <= fourth_volume_level_next;
         fourth_gain_trim_reg    <= fourth_gain_trim_next;
         fourth_phase_delay_reg  <= fourth_phase_delay_next;
         rsp_reg                 <= rsp_next;
      end
   end
   // The read data holds between reads; only the valid flag drops after one cycle.
   assign reg_rsp = rsp_reg;

   // ==========================================================================
   // Decoded trim outputs
   // Decodes are offsets from the 0 dB code, so clearing them in reset matches
   // the decode of the register reset values.
   channel_trim_type  third_trim_reg,  third_trim_next;
   channel_trim_type  fourth_trim_reg, fourth_trim_next;
   logic              mute_reg,        mute_next;
   logic signed [8:0] vol_reg,         vol_next;

   always_comb begin
      third_trim_next.gain_tenth_db  = $signed({1'b0, third_gain_trim_reg} - GAIN_ZERO_CODE);
      fourth_trim_next.gain_tenth_db = $signed({1'b0, fourth_gain_trim_reg} - GAIN_ZERO_CODE);
      third_trim_next.phase_delay    = third_phase_delay_reg;
      fourth_trim_next.phase_delay   = fourth_phase_delay_reg;
      // Volume code decode.
      // The level still follows the code when muted, so mute stands on its own.
      mute_next = (fourth_volume_level_reg == VOLUME_MUTE_CODE);
      vol_next  = $signed({1'b0, fourth_volume_level_reg} - VOLUME_ZERO_CODE);
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         third_trim_reg  <= '0;
         fourth_trim_reg <= '0;
         mute_reg        <= 1'b0;
         vol_reg         <= '0;
      end else begin
         third_trim_reg  <= third_trim_next;
         fourth_trim_reg <= fourth_trim_next;
         mute_reg        <= mute_next;
         vol_reg         <= vol_next;
      end
   end
   assign third_trim            = third_trim_reg;
   assign fourth_trim           = fourth_trim_reg;
   assign fourth_volume_mute    = mute_reg;
   assign fourth_volume_half_db = vol_reg;

   // ==========================================================================
   // Phase delay lines, one per channel
   // Tap N-1 holds the bit shifted in N ticks ago, so DELAY_DEPTH must stay at
   // least 255 for the full delay range. A zero delay bypasses the line.
   logic [7:0] delay_sel [2];
   assign delay_sel[0] = third_phase_delay_reg;
   assign delay_sel[1] = fourth_phase_delay_reg;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_delay
         logic [DELAY_DEPTH-1:0] line_reg, line_next;
         logic                   out_reg,  out_next;

         always_comb begin
            line_next = line_reg;
            // The line moves only on a modulator tick, so delays count modulator cycles.
            if (mod_tick) begin
               line_next = {line_reg[DELAY_DEPTH-2:0], pdm_in[ch]};
            end
            if (delay_sel[ch] == 8'h00) begin
               out_next = pdm_in[ch];
            end else begin
               out_next = line_reg[delay_sel[ch] - 8'h01];
            end
         end

         always_ff @(posedge clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
               line_reg <= '0;
               out_reg  <= 1'b0;
            end else begin
               line_reg <= line_next;
               out_reg  <= out_next;
            end
         end
         assign pdm_delayed[ch] = out_reg;
      end
   endgenerate

endmodule : channel_cal_volume_regs

// >>> bench/channel_cal_volume_regs_assertions.sv
// Concurrent checks on the register port and the decoded trim outputs.
`timescale 1ns/100ps
module channel_cal_volume_regs_assertions
   import cal_volume_pkg::*;
(
   input wire logic              clk,                  // Clock.
   input wire logic              rst_n,                // Reset, active low.
   input wire reg_req_type       reg_req,              // Register request.
   input wire reg_rsp_type       reg_rsp,              // Register answer.
   input wire channel_trim_type  third_trim,           // Channel 3 trims.
   input wire channel_trim_type  fourth_trim,          // Channel 4 trims.
   input wire logic              fourth_volume_mute,   // Channel 4 mute.
   input wire logic signed [8:0] fourth_volume_half_db // Channel 4 volume.
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========================================================================
   // Register port and decode
   a_read_answer: assert property (reg_req.rd |=> reg_rsp.valid)
      else $error("read strobe not answered");
   a_no_spurious: assert property (!reg_req.rd |=> !reg_rsp.valid)
      else $error("answer without read strobe");
   a_reserved_zero: assert property (reg_req.rd && reg_req.addr inside {8'h49, 8'h4e}
      |=> reg_rsp.data[3:0] == 4'h0) else $error("reserved gain bits not zero");
   a_gain3_decode: assert property (reg_req.wr && reg_req.addr == 8'h49 |-> ##2
      third_trim.gain_tenth_db == $signed({1'b0, $past(reg_req.wdata[7:4], 2)}) - 5'sd8)
      else $error("channel 3 gain decode wrong");
   a_gain4_decode: assert property (reg_req.wr && reg_req.addr == 8'h4e |-> ##2
      fourth_trim.gain_tenth_db == $signed({1'b0, $past(reg_req.wdata[7:4], 2)}) - 5'sd8)
      else $error("channel 4 gain decode wrong");
   a_phase3_copy: assert property (reg_req.wr && reg_req.addr == 8'h4a |-> ##2
      third_trim.phase_delay == $past(reg_req.wdata, 2)) else $error("channel 3 delay wrong");
   a_phase4_copy: assert property (reg_req.wr && reg_req.addr == 8'h4f |-> ##2
      fourth_trim.phase_delay == $past(reg_req.wdata, 2)) else $error("channel 4 delay wrong");
   a_volume_mute: assert property (reg_req.wr && reg_req.addr == 8'h4d |-> ##2
      fourth_volume_mute == ($past(reg_req.wdata, 2) == 8'h00)) else $error("mute decode wrong");
   a_volume_level: assert property (reg_req.wr && reg_req.addr == 8'h4d && reg_req.wdata != 0
      |-> ##2 fourth_volume_half_db == $signed({1'b0, $past(reg_req.wdata, 2)}) - 9'sd201)
      else $error("volume decode wrong");
endmodule : channel_cal_volume_regs_assertions

bind channel_cal_volume_regs channel_cal_volume_regs_assertions u_assertions (.clk(clk),
   .rst_n(rst_n), .reg_req(reg_req), .reg_rsp(reg_rsp), .third_trim(third_trim),
   .fourth_trim(fourth_trim), .fourth_volume_mute(fourth_volume_mute),
   .fourth_volume_half_db(fourth_volume_half_db));

// >>> bench/tb_channel_cal_volume_regs.sv
// Self-checking testbench for the channel 3 and 4 trim registers.
`timescale 1ns/100ps
module tb_channel_cal_volume_regs;
   import cal_volume_pkg::*;
   logic clk, rst_n, mod_tick, mute;
   logic [1:0] pdm_in, pdm_dly;
   logic signed [8:0] vol;
   reg_req_type reg_req;
   reg_rsp_type reg_rsp;
   channel_trim_type t3, t4;
   int miscompares = 0;
   int n_compared = 0;
   channel_cal_volume_regs #(.DELAY_DEPTH(255)) dut (.clk(clk), .rst_n(rst_n),
      .reg_req(reg_req), .reg_rsp(reg_rsp), .mod_tick(mod_tick), .pdm_in(pdm_in),
      .pdm_delayed(pdm_dly), .third_trim(t3), .fourth_trim(t4),
      .fourth_volume_mute(mute), .fourth_volume_half_db(vol));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ==========================================================================
   // Shared tasks
   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic give_verdict;
      $display("Compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk) reg_req <= '0;
      @(posedge clk) #1;
   endtask : wr_reg
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] e);
      @(posedge clk) reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk) reg_req <= '0;
      #1;
      check("valid", {8'h00, reg_rsp.valid}, 9'h001);
      check(what, {1'b0, reg_rsp.data}, {1'b0, e});
   endtask : rd_chk
   task automatic do_reset;
      @(posedge clk) rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
   endtask : do_reset
   // ==========================================================================
   // Scenarios
   task automatic t_reset;
      rd_chk("gain3", 8'h49, 8'h80);
      rd_chk("phase3", 8'h4a, 8'h00);
      rd_chk("volume4", 8'h4d, 8'hc9);
      rd_chk("gain4", 8'h4e, 8'h80);
      rd_chk("phase4", 8'h4f, 8'h00);
      rd_chk("unmapped", 8'h4b, 8'h00);
      check("g3 dec", 9'(t3.gain_tenth_db), 9'h000);
      check("g4 dec", 9'(t4.gain_tenth_db), 9'h000);
      check("mute", {8'h00, mute}, 9'h000);
      check("vol dec", vol, 9'h000);
   endtask : t_reset
   task automatic t_gain;
      wr_reg(8'h49, 8'h00);
      wr_reg(8'h4e, 8'hf0);
      wr_reg(8'h4b, 8'h55);
      rd_chk("gain3 w", 8'h49, 8'h00);
      rd_chk("gain4 w", 8'h4e, 8'hf0);
      rd_chk("unmapped w", 8'h4b, 8'h00);
      check("g3 min", 9'(t3.gain_tenth_db), -9'sd8);
      check("g4 max", 9'(t4.gain_tenth_db), 9'sd7);
   endtask : t_gain
   task automatic t_volume;
      logic [7:0] codes [4] = '{8'h00, 8'h01, 8'hc9, 8'hff};
      foreach (codes[i]) begin
         wr_reg(8'h4d, codes[i]);
         rd_chk("volume4 w", 8'h4d, codes[i]);
         check("mute", {8'h00, mute}, {8'h00, codes[i] == 8'h00});
         if (codes[i] != 8'h00) check("vol", vol, {1'b0, codes[i]} - 9'd201);
      end
   endtask : t_volume
   task automatic t_phase;
      int k3, k4;
      k3 = 0;
      k4 = 0;
      wr_reg(8'h4a, 8'hff);
      wr_reg(8'h4f, 8'h00);
      rd_chk("phase3 w", 8'h4a, 8'hff);
      check("p3 dec", {1'b0, t3.phase_delay}, 9'h0ff);
      check("p4 dec", {1'b0, t4.phase_delay}, 9'h000);
      @(posedge clk) pdm_in <= 2'b11;
      mod_tick <= 1'b1;
      for (int k = 1; k <= 300; k++) begin
         @(posedge clk) pdm_in <= 2'b00;
         #1;
         if (pdm_dly[0] === 1'b1 && k3 == 0) k3 = k;
         if (pdm_dly[1] === 1'b1 && k4 == 0) k4 = k;
      end
      @(posedge clk) mod_tick <= 1'b0;
      check("delay3", k3[8:0], 9'd256);
      check("delay4", k4[8:0], 9'd1);
   endtask : t_phase
   initial begin
      rst_n = 1'b0;
      reg_req = '0;
      mod_tick = 1'b0;
      pdm_in = 2'b00;
      do_reset;
      t_reset;
      t_gain;
      t_volume;
      t_phase;
      do_reset;
      t_reset;
      give_verdict;
   end
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      give_verdict;
   end
endmodule : tb_channel_cal_volume_regs
